//--- core/ixw_regs.svh
/*
  register offsets, field positions, reset values and cycle counts of the
  instruction execution block.
  assumes: included by its bare name from the core module.
*/
`ifndef IXW_REGS_SVH
`define IXW_REGS_SVH
// ************
// register map
// ************
`define IXW_OFS_INSTR 8'h00
`define IXW_OFS_STATUS 8'h04
`define IXW_OFS_FLAGS 8'h08
`define IXW_OFS_ACC 8'h0C
`define IXW_OFS_PC 8'h10
`define IXW_OFS_WDOG 8'h14
`define IXW_OFS_MADDR 8'h18
`define IXW_OFS_MDATA 8'h1C
`define IXW_OFS_STACK 8'h20
// ************
// fields and values
// ************
`define IXW_WAKE_BIT 0
`define IXW_PC_RST 10'h000
`define IXW_ACC_RST 8'h00
`define IXW_PCL_ADDR 6'h06
`define IXW_BCD_MAX 4'h9
`define IXW_BCD_ADJ 4'h6
`define IXW_MC_LAST 3'h3
`define IXW_MC2_LAST 3'h7
`endif

//--- core/ixw_pkg.sv
/*
  types of the instruction execution block.
  assumes: compiled before the core module.
*/
package ixw_pkg;
  // ************
  // operations
  // ************
  typedef enum logic [4:0] {
    IXW_OP_NOP = 5'b00000, IXW_OP_PRECLR_A = 5'b00001, IXW_OP_PRECLR_B = 5'b00010,
    IXW_OP_INV_MEM = 5'b00011, IXW_OP_INV_WORK = 5'b00100, IXW_OP_BCD_ADJ = 5'b00101,
    IXW_OP_MINUS_MEM = 5'b00110, IXW_OP_MINUS_WORK = 5'b00111, IXW_OP_HALT = 5'b01000,
    IXW_OP_PLUS_MEM = 5'b01001, IXW_OP_PLUS_WORK = 5'b01010, IXW_OP_GOTO = 5'b01011,
    IXW_OP_COPY_TO_WORK = 5'b01100, IXW_OP_COPY_IMM = 5'b01101,
    IXW_OP_COPY_TO_MEM = 5'b01110, IXW_OP_OR_WORK = 5'b01111, IXW_OP_OR_IMM = 5'b10000,
    IXW_OP_OR_INTO_MEM = 5'b10001, IXW_OP_SUB_EXIT = 5'b10010,
    IXW_OP_SUB_EXIT_IMM = 5'b10011, IXW_OP_IRQ_EXIT = 5'b10100,
    IXW_OP_ROTL_MEM = 5'b10101, IXW_OP_ROTL_WORK = 5'b10110
  } ixw_op_type;
  typedef enum logic [0:0] {IXW_ST_IDLE = 1'b0, IXW_ST_EXEC = 1'b1} ixw_state_type;
  // ************
  // carriers
  // ************
  typedef struct packed {
    logic [7:0] imm;
    logic [1:0] tgt_hi;
    logic [5:0] addr;
    logic [2:0] rsv;
    ixw_op_type op;
  } ixw_instr_type;
  typedef struct packed {
    logic global_irq_enable;
    logic wd_expired_flag;
    logic sleep_flag;
    logic ov;
    logic z;
    logic half_carry;
    logic c;
  } ixw_flags_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ixw_bus_type;
endpackage : ixw_pkg

//--- core/ixw_core.sv
/*
  execution unit for one range of an 8-bit controller instruction set,
  with accumulator, flags, 64-byte data memory, two-level stack, watchdog.
  assumes: bus master on clk_sys_in; strobes one cycle, never together.
*/
`timescale 1ns/1ns
`include "ixw_regs.svh"
module ixw_core #(
  parameter int WD_PRE_W = 8,
  parameter int WD_W = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // register bus
  input wire ixw_pkg::ixw_bus_type bus_in,
  output logic [31:0] rd_data_out,
  // core state
  output logic busy_out,
  output logic halted_out,
  output logic [9:0] pc_out
);
  import ixw_pkg::*;

  // ************
  // helpers
  // ************
  function automatic logic ixw_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : ixw_zero

  function automatic logic ixw_writes_mem(input ixw_op_type op);
    case (op)
      IXW_OP_INV_MEM, IXW_OP_BCD_ADJ, IXW_OP_MINUS_MEM, IXW_OP_PLUS_MEM,
      IXW_OP_COPY_TO_MEM, IXW_OP_OR_INTO_MEM, IXW_OP_ROTL_MEM: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : ixw_writes_mem

  function automatic logic ixw_two_mc(input ixw_instr_type i);
    case (i.op)
      IXW_OP_GOTO, IXW_OP_SUB_EXIT, IXW_OP_SUB_EXIT_IMM, IXW_OP_IRQ_EXIT: return 1'b1;
      default: return ixw_writes_mem(i.op) && (i.addr == `IXW_PCL_ADDR);
    endcase
  endfunction : ixw_two_mc

  // ************
  // state
  // ************
  ixw_state_type state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  ixw_instr_type ex_q, ex_d;
  logic [7:0] acc_q, acc_d;
  ixw_flags_type flags_q, flags_d;
  logic [9:0] pc_q, pc_d;
  logic [9:0] stk_q [2];
  logic [9:0] stk_d [2];
  logic sp_q, sp_d;
  logic [7:0] mem_q [64];
  logic [7:0] mem_d [64];
  logic [5:0] maddr_q, maddr_d;
  logic pre_a_q, pre_a_d;
  logic pre_b_q, pre_b_d;
  logic halted_q, halted_d;
  logic [WD_PRE_W-1:0] wpre_q, wpre_d;
  logic [WD_W-1:0] wdog_q, wdog_d;
  logic [31:0] rdata_q, rdata_d;

  logic [7:0] m_val;
  logic accept;
  logic commit;
  logic wovf;
  logic wd_set;
  logic [7:0] res;
  logic wr_acc;
  logic upd_z;
  logic nibble_carry_out;
  logic [3:0] lo_n;
  logic [4:0] hsum;
  logic [3:0] hi_n;

  assign m_val = mem_q[ex_q.addr];
  assign accept = bus_in.wr && (bus_in.addr == `IXW_OFS_INSTR) && (state_q == IXW_ST_IDLE)
                  && !halted_q;
  assign commit = (state_q == IXW_ST_EXEC)
                  && (cnt_q == (ixw_two_mc(ex_q) ? `IXW_MC2_LAST : `IXW_MC_LAST));
  assign wovf = &wpre_q;
  assign wd_set = wovf && (&wdog_q);

  // ************
  // next state
  // ************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ex_d = ex_q;
    acc_d = acc_q;
    flags_d = flags_q;
    pc_d = pc_q;
    stk_d = stk_q;
    sp_d = sp_q;
    mem_d = mem_q;
    maddr_d = maddr_q;
    pre_a_d = pre_a_q;
    pre_b_d = pre_b_q;
    halted_d = halted_q;
    rdata_d = 32'h0000_0000;
    res = 8'h00;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    nibble_carry_out = 1'b0;
    lo_n = acc_q[3:0];
    hsum = 5'h00;
    hi_n = acc_q[7:4];
    // watchdog prescaler and counter
    wpre_d = wpre_q + 1'b1;
    wdog_d = wdog_q;
    if (wovf) begin
      wdog_d = wdog_q + 1'b1;
    end
    // instruction issue
    if (accept) begin
      ex_d = bus_in.wdata[23:0];
      state_d = IXW_ST_EXEC;
      cnt_d = 3'h0;
    end
    // register writes while idle
    if (bus_in.wr && (state_q == IXW_ST_IDLE)) begin
      case (bus_in.addr)
        `IXW_OFS_STATUS: begin
          if (bus_in.wdata[`IXW_WAKE_BIT]) begin
            halted_d = 1'b0;
          end
        end
        `IXW_OFS_FLAGS: begin
          flags_d.c = bus_in.wdata[0];
          flags_d.half_carry = bus_in.wdata[1];
          flags_d.z = bus_in.wdata[2];
          flags_d.ov = bus_in.wdata[3];
          flags_d.global_irq_enable = bus_in.wdata[6];
        end
        `IXW_OFS_ACC: acc_d = bus_in.wdata[7:0];
        `IXW_OFS_MADDR: maddr_d = bus_in.wdata[5:0];
        `IXW_OFS_MDATA: mem_d[maddr_q] = bus_in.wdata[7:0];
        `IXW_OFS_STACK: begin
          stk_d[sp_q] = bus_in.wdata[9:0];
          sp_d = ~sp_q;
        end
        default: ;
      endcase
    end
    // execution
    if (state_q == IXW_ST_EXEC) begin
      cnt_d = cnt_q + 3'h1;
    end
    if (commit) begin
      state_d = IXW_ST_IDLE;
      pc_d = pc_q + 10'h001;
      case (ex_q.op)
        IXW_OP_PRECLR_A, IXW_OP_PRECLR_B: begin
          if ((ex_q.op == IXW_OP_PRECLR_A) ? pre_b_q : pre_a_q) begin
            wdog_d = '0;
            flags_d.sleep_flag = 1'b0;
            flags_d.wd_expired_flag = 1'b0;
            pre_a_d = 1'b0;
            pre_b_d = 1'b0;
          end else if (ex_q.op == IXW_OP_PRECLR_A) begin
            pre_a_d = 1'b1;
          end else begin
            pre_b_d = 1'b1;
          end
        end
        IXW_OP_INV_MEM: begin
          res = ~m_val;
          upd_z = 1'b1;
        end
        IXW_OP_INV_WORK: begin
          res = ~m_val;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        IXW_OP_BCD_ADJ: begin
          if ((acc_q[3:0] > `IXW_BCD_MAX) || flags_q.half_carry) begin
            lo_n = acc_q[3:0] + `IXW_BCD_ADJ;
            nibble_carry_out = ~flags_q.half_carry;
          end
          hsum = {1'b0, acc_q[7:4]} + {4'h0, nibble_carry_out};
          if ((hsum > {1'b0, `IXW_BCD_MAX}) || flags_q.c) begin
            hi_n = acc_q[7:4] + `IXW_BCD_ADJ + {3'h0, nibble_carry_out};
            flags_d.c = 1'b1;
          end else begin
            hi_n = hsum[3:0];
          end
          res = {hi_n, lo_n};
        end
        IXW_OP_MINUS_MEM: begin
          res = m_val - 8'h01;
          upd_z = 1'b1;
        end
        IXW_OP_MINUS_WORK: begin
          res = m_val - 8'h01;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        IXW_OP_HALT: begin
          halted_d = 1'b1;
          wdog_d = '0;
          wpre_d = '0;
          flags_d.sleep_flag = 1'b1;
          flags_d.wd_expired_flag = 1'b0;
        end
        IXW_OP_PLUS_MEM: begin
          res = m_val + 8'h01;
          upd_z = 1'b1;
        end
        IXW_OP_PLUS_WORK: begin
          res = m_val + 8'h01;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        IXW_OP_GOTO: pc_d = {ex_q.tgt_hi, ex_q.imm};
        IXW_OP_COPY_TO_WORK: begin
          res = m_val;
          wr_acc = 1'b1;
        end
        IXW_OP_COPY_TO_MEM: res = acc_q;
        IXW_OP_COPY_IMM: begin
          res = ex_q.imm;
          wr_acc = 1'b1;
        end
        IXW_OP_OR_WORK: begin
          res = acc_q | m_val;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        IXW_OP_OR_IMM: begin
          res = acc_q | ex_q.imm;
          wr_acc = 1'b1;
          upd_z = 1'b1;
        end
        IXW_OP_OR_INTO_MEM: begin
          res = acc_q | m_val;
          upd_z = 1'b1;
        end
        IXW_OP_SUB_EXIT: begin
          pc_d = stk_q[~sp_q];
          sp_d = ~sp_q;
        end
        IXW_OP_SUB_EXIT_IMM: begin
          pc_d = stk_q[~sp_q];
          sp_d = ~sp_q;
          res = ex_q.imm;
          wr_acc = 1'b1;
        end
        IXW_OP_IRQ_EXIT: begin
          pc_d = stk_q[~sp_q];
          sp_d = ~sp_q;
          flags_d.global_irq_enable = 1'b1;
        end
        IXW_OP_ROTL_MEM: res = {m_val[6:0], m_val[7]};
        IXW_OP_ROTL_WORK: begin
          res = {m_val[6:0], m_val[7]};
          wr_acc = 1'b1;
        end
        default: ;
      endcase
      if (wr_acc) begin
        acc_d = res;
      end
      if (ixw_writes_mem(ex_q.op)) begin
        mem_d[ex_q.addr] = res;
        if (ex_q.addr == `IXW_PCL_ADDR) begin
          pc_d = {pc_q[9:8], res};
        end
      end
      if (upd_z) begin
        flags_d.z = ixw_zero(res);
      end
    end
    // watchdog expiry wins over any clear, and wakes the core
    if (wd_set) begin
      flags_d.wd_expired_flag = 1'b1;
      halted_d = 1'b0;
    end
    // register reads
    if (bus_in.rd) begin
      case (bus_in.addr)
        `IXW_OFS_STATUS: rdata_d = {22'h0, halted_q, state_q == IXW_ST_EXEC, 1'b0, flags_q};
        `IXW_OFS_FLAGS: rdata_d = {25'h0, flags_q};
        `IXW_OFS_ACC: rdata_d = {24'h0, acc_q};
        `IXW_OFS_PC: rdata_d = {22'h0, pc_q};
        `IXW_OFS_WDOG: rdata_d = 32'(wdog_q);
        `IXW_OFS_MADDR: rdata_d = {26'h0, maddr_q};
        `IXW_OFS_MDATA: rdata_d = {24'h0, mem_q[maddr_q]};
        `IXW_OFS_STACK: rdata_d = {22'h0, stk_q[~sp_q]};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ************
  // registers
  // ************
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= IXW_ST_IDLE;
      cnt_q <= 3'h0;
      ex_q <= '0;
      acc_q <= `IXW_ACC_RST;
      flags_q <= '0;
      pc_q <= `IXW_PC_RST;
      stk_q <= '{default: 10'h000};
      sp_q <= 1'b0;
      mem_q <= '{default: 8'h00};
      maddr_q <= 6'h00;
      pre_a_q <= 1'b0;
      pre_b_q <= 1'b0;
      halted_q <= 1'b0;
      wpre_q <= '0;
      wdog_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ex_q <= ex_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      stk_q <= stk_d;
      sp_q <= sp_d;
      mem_q <= mem_d;
      maddr_q <= maddr_d;
      pre_a_q <= pre_a_d;
      pre_b_q <= pre_b_d;
      halted_q <= halted_d;
      wpre_q <= wpre_d;
      wdog_q <= wdog_d;
      rdata_q <= rdata_d;
    end
  end

  assign rd_data_out = rdata_q;
  assign busy_out = state_q == IXW_ST_EXEC;
  assign halted_out = halted_q;
  assign pc_out = pc_q;

  // ************
  // checks
  // ************
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  chk_pair_clear: assert property (
    commit && ex_q.op == IXW_OP_PRECLR_A && pre_b_q && !wd_set
    |=> wdog_q == '0 && !flags_q.sleep_flag && !flags_q.wd_expired_flag)
    else $error("pre-clear pair did not clear watchdog");
  chk_pair_forget: assert property (
    commit && ex_q.op == IXW_OP_PRECLR_B && pre_a_q |=> !pre_a_q && !pre_b_q)
    else $error("pre-clear records kept after pair");
  chk_single_hold: assert property (
    commit && ex_q.op == IXW_OP_PRECLR_A && !pre_b_q && !wd_set
    |=> pre_a_q && $stable(flags_q))
    else $error("single pre-clear changed flags");
  chk_invert_mem: assert property (
    commit && ex_q.op == IXW_OP_INV_MEM
    |=> mem_q[$past(ex_q.addr)] == ~$past(m_val) && flags_q.z == ($past(m_val) == 8'hFF))
    else $error("invert memory result wrong");
  chk_minus_work: assert property (
    commit && ex_q.op == IXW_OP_MINUS_WORK
    |=> acc_q == $past(m_val) - 8'h01 && mem_q[$past(ex_q.addr)] == $past(m_val))
    else $error("minus one to work wrong");
  chk_halt_entry: assert property (
    commit && ex_q.op == IXW_OP_HALT && !wd_set |=> halted_q && flags_q.sleep_flag
    && !flags_q.wd_expired_flag && pc_q == $past(pc_q) + 10'h001)
    else $error("power-down entry wrong");
  chk_mc_short: assert property (
    accept && bus_in.wdata[4:0] == IXW_OP_NOP |=> busy_out [*4] ##1 !busy_out)
    else $error("machine cycle not four clocks");
  chk_exit_long: assert property (
    accept && bus_in.wdata[4:0] == IXW_OP_SUB_EXIT |=> busy_out [*8] ##1 !busy_out)
    else $error("subroutine exit not two machine cycles");
  chk_irq_exit: assert property (commit && ex_q.op == IXW_OP_IRQ_EXIT
    |=> flags_q.global_irq_enable && pc_q == $past(stk_q[~sp_q]))
    else $error("interrupt exit wrong");
  chk_rotl_work: assert property (
    commit && ex_q.op == IXW_OP_ROTL_WORK && !wd_set
    |=> acc_q == {$past(m_val[6:0]), $past(m_val[7])} && $stable(flags_q))
    else $error("rotate left to work wrong");
  chk_goto_load: assert property (
    commit && ex_q.op == IXW_OP_GOTO |=> pc_q == $past({ex_q.tgt_hi, ex_q.imm}))
    else $error("goto target wrong");

  cov_pair: cover property (commit && ex_q.op == IXW_OP_PRECLR_B && pre_a_q);
  cov_halt: cover property (commit && ex_q.op == IXW_OP_HALT);
  cov_adjust: cover property (commit && ex_q.op == IXW_OP_BCD_ADJ && flags_q.half_carry);
  cov_pcl: cover property (commit && ixw_writes_mem(ex_q.op) && ex_q.addr == `IXW_PCL_ADDR);
endmodule : ixw_core

//--- sim/ixw_core_tb.sv
/*
  self-checking bench for the instruction execution block: drives the
  register bus, issues instructions, reads back state and compares.
  assumes: ixw_pkg and ixw_regs.svh from core/, default watchdog widths.
*/
`timescale 1ns/1ns
`include "ixw_regs.svh"
module ixw_core_tb;
  import ixw_pkg::*;
  // ************
  // signals
  // ************
  logic clk_sys_in;
  logic reset_in;
  ixw_bus_type bus_in;
  logic [31:0] rd_data_out;
  logic busy_out;
  logic halted_out;
  logic [9:0] pc_out;
  int error_cnt;
  int comparisons;
  int nbusy;
  logic [31:0] rv;
  logic [9:0] pc_s;

  ixw_core u_dut (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .bus_in(bus_in),
    .rd_data_out(rd_data_out),
    .busy_out(busy_out),
    .halted_out(halted_out),
    .pc_out(pc_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // ************
  // helpers
  // ************
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    bus_in.wr <= 1'b1;
    bus_in.addr <= a;
    bus_in.wdata <= d;
    @(posedge clk_sys_in);
    bus_in.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    bus_in.rd <= 1'b1;
    bus_in.addr <= a;
    @(posedge clk_sys_in);
    bus_in.rd <= 1'b0;
    #1 d = rd_data_out;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask : chk_rd

  task automatic mem_set(input logic [5:0] a, input logic [7:0] d);
    wr(`IXW_OFS_MADDR, {26'h0, a});
    wr(`IXW_OFS_MDATA, {24'h0, d});
  endtask : mem_set

  task automatic chk_mem(input logic [5:0] a, input logic [7:0] exp);
    wr(`IXW_OFS_MADDR, {26'h0, a});
    chk_rd(`IXW_OFS_MDATA, {24'h0, exp});
  endtask : chk_mem

  task automatic wait_idle();
    nbusy = 0;
    #1;
    while (busy_out !== 1'b0) begin
      if (nbusy > 40) begin
        error_cnt++;
        $display("mismatch at %0t busy count %h expected %h", $time, nbusy, 0);
        complete_run();
      end
      @(posedge clk_sys_in);
      #1;
      nbusy++;
    end
  endtask : wait_idle

  function automatic logic [31:0] mk(input ixw_op_type op, input logic [5:0] a,
                                     input logic [7:0] imm, input logic [1:0] hi);
    return {8'h00, imm, hi, a, 3'h0, op};
  endfunction : mk

  task automatic go(input ixw_op_type op, input logic [5:0] a, input logic [7:0] imm);
    wr(`IXW_OFS_INSTR, mk(op, a, imm, 2'h0));
    wait_idle();
  endtask : go
  // ************
  // scenarios
  // ************
  task automatic t_reset();
    chk_rd(`IXW_OFS_ACC, 32'h0);
    chk_rd(`IXW_OFS_PC, 32'h0);
    chk_rd(`IXW_OFS_FLAGS, 32'h0);
    chk_rd(`IXW_OFS_STATUS, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_nop();
    go(IXW_OP_NOP, 6'h00, 8'h00);
    chk(32'(nbusy), 32'h4);
    chk({22'h0, pc_out}, 32'h1);
    wr(`IXW_OFS_INSTR, mk(IXW_OP_NOP, 6'h00, 8'h00, 2'h0));
    wr(`IXW_OFS_ACC, 32'h33);
    wait_idle();
    chk_rd(`IXW_OFS_ACC, 32'h0);
    chk({22'h0, pc_out}, 32'h2);
    $display("test nop done");
  endtask : t_nop

  task automatic t_invert();
    mem_set(6'h05, 8'hFF);
    go(IXW_OP_INV_MEM, 6'h05, 8'h00);
    chk_mem(6'h05, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h04);
    go(IXW_OP_INV_WORK, 6'h05, 8'h00);
    chk_rd(`IXW_OFS_ACC, 32'hFF);
    chk_mem(6'h05, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h00);
    $display("test invert done");
  endtask : t_invert

  task automatic t_step();
    wr(`IXW_OFS_FLAGS, 32'h03);
    mem_set(6'h07, 8'h00);
    go(IXW_OP_MINUS_WORK, 6'h07, 8'h00);
    chk_rd(`IXW_OFS_ACC, 32'hFF);
    chk_mem(6'h07, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h03);
    go(IXW_OP_PLUS_MEM, 6'h07, 8'h00);
    chk_mem(6'h07, 8'h01);
    go(IXW_OP_MINUS_MEM, 6'h07, 8'h00);
    chk_mem(6'h07, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h07);
    go(IXW_OP_PLUS_WORK, 6'h07, 8'h00);
    chk_rd(`IXW_OFS_ACC, 32'h01);
    chk_rd(`IXW_OFS_FLAGS, 32'h03);
    $display("test step done");
  endtask : t_step

  task automatic t_adjust();
    wr(`IXW_OFS_ACC, 32'h9B);
    wr(`IXW_OFS_FLAGS, 32'h00);
    go(IXW_OP_BCD_ADJ, 6'h09, 8'h00);
    chk_mem(6'h09, 8'h01);
    chk_rd(`IXW_OFS_FLAGS, 32'h01);
    wr(`IXW_OFS_ACC, 32'h45);
    wr(`IXW_OFS_FLAGS, 32'h02);
    go(IXW_OP_BCD_ADJ, 6'h09, 8'h00);
    chk_mem(6'h09, 8'h4B);
    chk_rd(`IXW_OFS_FLAGS, 32'h02);
    chk_rd(`IXW_OFS_ACC, 32'h45);
    wr(`IXW_OFS_ACC, 32'h12);
    wr(`IXW_OFS_FLAGS, 32'h01);
    go(IXW_OP_BCD_ADJ, 6'h09, 8'h00);
    chk_mem(6'h09, 8'h72);
    chk_rd(`IXW_OFS_FLAGS, 32'h01);
    $display("test adjust done");
  endtask : t_adjust

  task automatic t_copy_or();
    wr(`IXW_OFS_FLAGS, 32'h07);
    go(IXW_OP_COPY_IMM, 6'h00, 8'h5A);
    chk_rd(`IXW_OFS_ACC, 32'h5A);
    chk_rd(`IXW_OFS_FLAGS, 32'h07);
    go(IXW_OP_COPY_TO_MEM, 6'h0A, 8'h00);
    chk_mem(6'h0A, 8'h5A);
    go(IXW_OP_OR_IMM, 6'h00, 8'hA5);
    chk_rd(`IXW_OFS_ACC, 32'hFF);
    chk_rd(`IXW_OFS_FLAGS, 32'h03);
    mem_set(6'h0B, 8'h00);
    go(IXW_OP_COPY_TO_WORK, 6'h0B, 8'h00);
    chk_rd(`IXW_OFS_ACC, 32'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h03);
    go(IXW_OP_OR_WORK, 6'h0B, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h07);
    go(IXW_OP_COPY_IMM, 6'h00, 8'h0F);
    go(IXW_OP_OR_INTO_MEM, 6'h0A, 8'h00);
    chk_mem(6'h0A, 8'h5F);
    chk_rd(`IXW_OFS_ACC, 32'h0F);
    chk_rd(`IXW_OFS_FLAGS, 32'h03);
    $display("test copy or done");
  endtask : t_copy_or

  task automatic t_rotate();
    wr(`IXW_OFS_FLAGS, 32'h00);
    mem_set(6'h0C, 8'h81);
    go(IXW_OP_ROTL_WORK, 6'h0C, 8'h00);
    chk_rd(`IXW_OFS_ACC, 32'h03);
    chk_mem(6'h0C, 8'h81);
    go(IXW_OP_ROTL_MEM, 6'h0C, 8'h00);
    chk_mem(6'h0C, 8'h03);
    chk_rd(`IXW_OFS_FLAGS, 32'h00);
    $display("test rotate done");
  endtask : t_rotate

  task automatic t_flow();
    wr(`IXW_OFS_INSTR, mk(IXW_OP_GOTO, 6'h00, 8'hA5, 2'h2));
    wait_idle();
    chk({22'h0, pc_out}, 32'h2A5);
    chk(32'(nbusy), 32'h8);
    wr(`IXW_OFS_STACK, 32'h123);
    go(IXW_OP_SUB_EXIT, 6'h00, 8'h00);
    chk({22'h0, pc_out}, 32'h123);
    chk(32'(nbusy), 32'h8);
    wr(`IXW_OFS_STACK, 32'h55);
    go(IXW_OP_SUB_EXIT_IMM, 6'h00, 8'h77);
    chk({22'h0, pc_out}, 32'h55);
    chk_rd(`IXW_OFS_ACC, 32'h77);
    wr(`IXW_OFS_STACK, 32'h10);
    go(IXW_OP_IRQ_EXIT, 6'h00, 8'h00);
    chk({22'h0, pc_out}, 32'h10);
    chk_rd(`IXW_OFS_FLAGS, 32'h40);
    go(IXW_OP_COPY_IMM, 6'h00, 8'h3C);
    go(IXW_OP_COPY_TO_MEM, `IXW_PCL_ADDR, 8'h00);
    chk({22'h0, pc_out}, 32'h03C);
    chk(32'(nbusy), 32'h8);
    chk_mem(`IXW_PCL_ADDR, 8'h3C);
    $display("test flow done");
  endtask : t_flow

  task automatic t_halt();
    wr(`IXW_OFS_FLAGS, 32'h00);
    pc_s = pc_out;
    go(IXW_OP_HALT, 6'h00, 8'h00);
    chk({31'h0, halted_out}, 32'h1);
    chk({22'h0, pc_out}, {22'h0, pc_s + 10'h001});
    chk_rd(`IXW_OFS_FLAGS, 32'h10);
    chk_rd(`IXW_OFS_WDOG, 32'h0);
    wr(`IXW_OFS_INSTR, mk(IXW_OP_NOP, 6'h00, 8'h00, 2'h0));
    #1 chk({31'h0, busy_out}, 32'h0);
    repeat (5) @(posedge clk_sys_in);
    #1 chk({22'h0, pc_out}, {22'h0, pc_s + 10'h001});
    chk_rd(`IXW_OFS_ACC, 32'h3C);
    wr(`IXW_OFS_STATUS, 32'h1);
    #1 chk({31'h0, halted_out}, 32'h0);
    $display("test halt done");
  endtask : t_halt

  task automatic t_preclear();
    go(IXW_OP_PRECLR_A, 6'h00, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h10);
    go(IXW_OP_PRECLR_A, 6'h00, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h10);
    repeat (600) @(posedge clk_sys_in);
    chk_rd(`IXW_OFS_WDOG, 32'h2);
    go(IXW_OP_PRECLR_B, 6'h00, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h00);
    chk_rd(`IXW_OFS_WDOG, 32'h0);
    go(IXW_OP_HALT, 6'h00, 8'h00);
    wr(`IXW_OFS_STATUS, 32'h1);
    go(IXW_OP_PRECLR_B, 6'h00, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h10);
    go(IXW_OP_PRECLR_A, 6'h00, 8'h00);
    chk_rd(`IXW_OFS_FLAGS, 32'h00);
    $display("test preclear done");
  endtask : t_preclear
  // ************
  // main sequence
  // ************
  initial begin
    error_cnt = 0;
    comparisons = 0;
    reset_in = 1'b1;
    bus_in = '0;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_reset();
    t_nop();
    t_invert();
    t_step();
    t_adjust();
    t_copy_or();
    t_rotate();
    t_flow();
    t_halt();
    t_preclear();
    complete_run();
  end
endmodule : ixw_core_tb
